// [src/mbas_slave.v]
// Serial register slave: decodes read, single write and multiple write
// requests, updates the register map and builds the normal reply.
// Assumes characters from a UART already framed as bytes, one per cycle.
`timescale 1ns/1ps
`include "mbas_regs.vh"

module mbas_slave #(
  parameter MAX_REGS = 16
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [7:0] RX_CHAR,
  input wire RX_VALID,
  output wire [7:0] TX_CHAR,
  output wire TX_VALID,
  input wire TX_READY,
  input wire [7:0] SLAVE_ADDR,
  input wire [15:0] OUTLET_TEMP,
  input wire [15:0] OUTLET_PRESS,
  input wire [15:0] RESISTIVITY,
  input wire [15:0] STATUS_FLAGS_1,
  input wire [15:0] ALARM_FLAGS_1,
  input wire [15:0] ALARM_FLAGS_2,
  output wire [15:0] SETPOINT,
  output wire [15:0] RUN_STOP,
  output wire RUN_CMD,
  output wire BUSY
);

  ////////////////////////////////////////////////////////////////////////
  // Sizes and states

  localparam IW = 6;
  localparam BUF_BYTES = 8 + 2 * MAX_REGS;
  localparam [IW-1:0] BUF_FULL = BUF_BYTES;
  localparam [15:0] MAX_CNT = MAX_REGS;

  localparam ST_RECV = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_RESP = 3'b100;

  reg [2:0] state_reg;
  reg [7:0] buf_mem [0:BUF_BYTES-1];
  reg [IW-1:0] len_reg;
  reg ovf_reg;
  reg [7:0] sum_reg;
  reg [7:0] fc_reg;
  reg [15:0] head_reg;
  reg [15:0] cnt_reg;
  reg [15:0] idx_reg;
  reg [IW-1:0] base_reg;
  reg [15:0] rlen_reg;
  reg [15:0] ridx_reg;
  reg [15:0] setpoint_reg;
  reg [15:0] run_stop_reg;
  reg run_cmd_reg;

  wire rx_sof;
  wire rx_bv;
  wire [7:0] rx_byte;
  wire rx_eof;
  wire out_ready;

  ////////////////////////////////////////////////////////////////////////
  // Framing front and back ends

  mbas_char_rx u_rx (
    .clk(CLOCK),
    .rst(SYS_RST),
    .char_in(RX_CHAR),
    .char_valid(RX_VALID),
    .sof_reg(rx_sof),
    .byte_valid_reg(rx_bv),
    .byte_reg(rx_byte),
    .eof_reg(rx_eof)
  );

  reg [7:0] resp_byte;
  wire out_valid = (state_reg == ST_RESP);
  wire out_last = (ridx_reg == rlen_reg - 16'h0001);

  mbas_frame_tx u_tx (
    .clk(CLOCK),
    .rst(SYS_RST),
    .byte_in(resp_byte),
    .byte_valid(out_valid),
    .byte_last(out_last),
    .byte_ready(out_ready),
    .tx_data(TX_CHAR),
    .tx_valid(TX_VALID),
    .tx_ready(TX_READY)
  );

  ////////////////////////////////////////////////////////////////////////
  // Request checks

  // Big-endian word from two buffered bytes
  function [15:0] word_at;
    input [IW-1:0] pos;
    begin
      word_at = {buf_mem[pos], buf_mem[pos + 6'h01]};
    end
  endfunction

  wire [15:0] len_w = {{(16 - IW){1'b0}}, len_reg};
  wire [7:0] req_fc = buf_mem[`MBAS_OFS_FC];
  wire [15:0] req_head = word_at(`MBAS_OFS_HEAD);
  wire [15:0] req_cnt = word_at(`MBAS_OFS_CNT);
  wire [15:0] req_cnt2 = {req_cnt[14:0], 1'b0};
  wire cnt_ok = (req_cnt != 16'h0000) && (req_cnt <= MAX_CNT);

  wire len_min_ok = (len_w >= `MBAS_LEN_READ);
  wire sum_ok = (sum_reg == 8'h00);
  wire addr_ok = (buf_mem[`MBAS_OFS_SLAVE] == SLAVE_ADDR);
  wire frame_ok = !ovf_reg && len_min_ok && sum_ok && addr_ok;
  wire read_ok = (req_fc == `MBAS_FC_READ) && (len_w == `MBAS_LEN_READ) && cnt_ok;
  wire wr1_ok = (req_fc == `MBAS_FC_WR1) && (len_w == `MBAS_LEN_WR1);
  wire wrn_ok = (req_fc == `MBAS_FC_WRN) && cnt_ok &&
                (buf_mem[`MBAS_OFS_BCNT] == req_cnt2[7:0]) &&
                (len_w == `MBAS_LEN_WRN_HDR + req_cnt2);

  ////////////////////////////////////////////////////////////////////////
  // Register map access

  wire [IW-1:0] wr_pos = base_reg + {idx_reg[IW-2:0], 1'b0};
  wire [15:0] wr_addr = head_reg + idx_reg;
  wire [15:0] wr_data = word_at(wr_pos);
  wire wr_en = (state_reg == ST_EXEC);

  wire [15:0] rd_off = ridx_reg - `MBAS_RD_DATA_POS;
  wire [15:0] rd_addr = head_reg + {1'b0, rd_off[15:1]};
  reg [15:0] rd_word;

  always @* begin
    case (rd_addr)
      `MBAS_A_TEMP: rd_word = OUTLET_TEMP;
      `MBAS_A_RSVD: rd_word = `MBAS_RST_WORD;
      `MBAS_A_PRESS: rd_word = OUTLET_PRESS;
      `MBAS_A_RESIST: rd_word = RESISTIVITY;
      `MBAS_A_STAT1: rd_word = STATUS_FLAGS_1;
      `MBAS_A_ALARM1: rd_word = ALARM_FLAGS_1;
      `MBAS_A_ALARM2: rd_word = ALARM_FLAGS_2;
      `MBAS_A_SETPT: rd_word = setpoint_reg;
      `MBAS_A_RUNSTOP: rd_word = run_stop_reg;
      default: rd_word = `MBAS_RST_WORD;
    endcase
  end

  // Reply bytes: echo of slave and function, then per-function data
  always @* begin
    if (fc_reg != `MBAS_FC_READ || ridx_reg < `MBAS_RD_BCNT_POS) begin
      resp_byte = buf_mem[ridx_reg[IW-1:0]];
    end else if (ridx_reg == `MBAS_RD_BCNT_POS) begin
      resp_byte = {cnt_reg[6:0], 1'b0};
    end else if (rd_off[0]) begin
      resp_byte = rd_word[7:0];
    end else begin
      resp_byte = rd_word[15:8];
    end
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      setpoint_reg <= `MBAS_RST_WORD;
      run_stop_reg <= `MBAS_RST_WORD;
      run_cmd_reg <= 1'b0;
    end else if (wr_en) begin
      if (wr_addr == `MBAS_A_SETPT) begin
        setpoint_reg <= wr_data;
      end
      if (wr_addr == `MBAS_A_RUNSTOP) begin
        run_stop_reg <= wr_data;
        run_cmd_reg <= (wr_data == `MBAS_RUN_VALUE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      len_reg <= {IW{1'b0}};
      ovf_reg <= 1'b0;
      sum_reg <= 8'h00;
    end else if (state_reg == ST_RECV) begin
      if (rx_sof) begin
        len_reg <= {IW{1'b0}};
        ovf_reg <= 1'b0;
        sum_reg <= 8'h00;
      end else if (rx_bv) begin
        if (len_reg == BUF_FULL) begin
          ovf_reg <= 1'b1;
        end else begin
          buf_mem[len_reg] <= rx_byte;
          len_reg <= len_reg + 6'h01;
          sum_reg <= sum_reg + rx_byte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer

  reg [2:0] state_next;
  reg [7:0] fc_next;
  reg [15:0] head_next;
  reg [15:0] cnt_next;
  reg [15:0] idx_next;
  reg [IW-1:0] base_next;
  reg [15:0] rlen_next;
  reg [15:0] ridx_next;

  always @* begin
    state_next = state_reg;
    fc_next = fc_reg;
    head_next = head_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    base_next = base_reg;
    rlen_next = rlen_reg;
    ridx_next = ridx_reg;
    case (state_reg)
      ST_RECV: begin
        if (rx_eof && frame_ok) begin
          fc_next = req_fc;
          head_next = req_head;
          idx_next = 16'h0000;
          ridx_next = 16'h0000;
          if (read_ok) begin
            cnt_next = req_cnt;
            rlen_next = `MBAS_RD_DATA_POS + req_cnt2;
            state_next = ST_RESP;
          end else if (wr1_ok) begin
            cnt_next = 16'h0001;
            base_next = `MBAS_OFS_WR1_DATA;
            rlen_next = `MBAS_ECHO_LEN;
            state_next = ST_EXEC;
          end else if (wrn_ok) begin
            cnt_next = req_cnt;
            base_next = `MBAS_OFS_WRN_DATA;
            rlen_next = `MBAS_ECHO_LEN;
            state_next = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        idx_next = idx_reg + 16'h0001;
        if (idx_next == cnt_reg) begin
          state_next = ST_RESP;
        end
      end
      ST_RESP: begin
        if (out_ready) begin
          ridx_next = ridx_reg + 16'h0001;
          if (out_last) begin
            state_next = ST_RECV;
          end
        end
      end
      default: state_next = ST_RECV;
    endcase
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_reg <= ST_RECV;
      fc_reg <= 8'h00;
      head_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      idx_reg <= 16'h0000;
      base_reg <= {IW{1'b0}};
      rlen_reg <= 16'h0000;
      ridx_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      fc_reg <= fc_next;
      head_reg <= head_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      base_reg <= base_next;
      rlen_reg <= rlen_next;
      ridx_reg <= ridx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign SETPOINT = setpoint_reg;
  assign RUN_STOP = run_stop_reg;
  assign RUN_CMD = run_cmd_reg;
  assign BUSY = (state_reg != ST_RECV) || TX_VALID;

endmodule

// [src/mbas_regs.vh]
// Constants for the ASCII-framed serial register slave.
// Included by the slave design files; holds definitions only.
//
// Contract
// - Read returns count registers from head address
// - Read reply: byte count, then words high first
// - Single write stores value at given address
// - Single write reply echoes request unchanged
// - Multiple write stores consecutive registers from head
// - Multiple write reply returns head and count only
// - Reply repeats function code 03, 06, 10
// - Fixed map of readable registers fluid_outlet_temperature-0006h
// - Setpoint writable at fluid_temperature_setpoint
// - Writing one to 000Ch commands run
// - Colon starts, CR LF ends, colon clears
// - Check byte mismatch discards the frame
// - Answer only own configured slave address
// - Transmit only in reply to a request
`ifndef MBAS_REGS_VH
`define MBAS_REGS_VH

// Framing characters
`define MBAS_CH_COLON 8'h3A
`define MBAS_CH_CR 8'h0D
`define MBAS_CH_LF 8'h0A

// Function codes
`define MBAS_FC_READ 8'h03
`define MBAS_FC_WR1 8'h06
`define MBAS_FC_WRN 8'h10

// Register addresses
`define MBAS_A_TEMP 16'h0000
`define MBAS_A_RSVD 16'h0001
`define MBAS_A_PRESS 16'h0002
`define MBAS_A_RESIST 16'h0003
`define MBAS_A_STAT1 16'h0004
`define MBAS_A_ALARM1 16'h0005
`define MBAS_A_ALARM2 16'h0006
`define MBAS_A_SETPT 16'h000B
`define MBAS_A_RUNSTOP 16'h000C

// Register values
`define MBAS_RST_WORD 16'h0000
`define MBAS_RUN_VALUE 16'h0001

// Byte positions in a decoded request
`define MBAS_OFS_SLAVE 6'h00
`define MBAS_OFS_FC 6'h01
`define MBAS_OFS_HEAD 6'h02
`define MBAS_OFS_CNT 6'h04
`define MBAS_OFS_BCNT 6'h06
`define MBAS_OFS_WR1_DATA 6'h04
`define MBAS_OFS_WRN_DATA 6'h07

// Frame lengths in bytes, check byte included
`define MBAS_LEN_READ 16'h0007
`define MBAS_LEN_WR1 16'h0007
`define MBAS_LEN_WRN_HDR 16'h0008

// Reply layout
`define MBAS_RD_BCNT_POS 16'h0002
`define MBAS_RD_DATA_POS 16'h0003
`define MBAS_ECHO_LEN 16'h0006

`endif

// [src/mbas_char_rx.v]
// Character receiver: turns ASCII frame characters into decoded bytes.
// Assumes one character per valid cycle, synchronous to clk.
`timescale 1ns/1ps
`include "mbas_regs.vh"

module mbas_char_rx (
  input wire clk,
  input wire rst,
  input wire [7:0] char_in,
  input wire char_valid,
  output reg sof_reg,
  output reg byte_valid_reg,
  output reg [7:0] byte_reg,
  output reg eof_reg
);

  reg in_frame_reg;
  reg half_reg;
  reg cr_reg;
  reg [3:0] nib_reg;

  function is_hex;
    input [7:0] c;
    begin
      is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
               (c >= 8'h61 && c <= 8'h66);
    end
  endfunction

  function [3:0] hex_val;
    input [7:0] c;
    begin
      if (c <= 8'h39) begin
        hex_val = c[3:0];
      end else begin
        hex_val = c[3:0] + 4'h9;
      end
    end
  endfunction

  always @(posedge clk) begin
    if (rst) begin
      in_frame_reg <= 1'b0;
      half_reg <= 1'b0;
      cr_reg <= 1'b0;
      nib_reg <= 4'h0;
      sof_reg <= 1'b0;
      byte_valid_reg <= 1'b0;
      byte_reg <= 8'h00;
      eof_reg <= 1'b0;
    end else begin
      sof_reg <= 1'b0;
      byte_valid_reg <= 1'b0;
      eof_reg <= 1'b0;
      if (char_valid) begin
        if (char_in == `MBAS_CH_COLON) begin
          in_frame_reg <= 1'b1;
          half_reg <= 1'b0;
          cr_reg <= 1'b0;
          sof_reg <= 1'b1;
        end else if (in_frame_reg) begin
          if (cr_reg) begin
            in_frame_reg <= 1'b0;
            eof_reg <= (char_in == `MBAS_CH_LF);
          end else if (char_in == `MBAS_CH_CR) begin
            if (half_reg) begin
              in_frame_reg <= 1'b0;
            end else begin
              cr_reg <= 1'b1;
            end
          end else if (is_hex(char_in)) begin
            if (half_reg) begin
              byte_reg <= {nib_reg, hex_val(char_in)};
              byte_valid_reg <= 1'b1;
            end else begin
              nib_reg <= hex_val(char_in);
            end
            half_reg <= ~half_reg;
          end else begin
            in_frame_reg <= 1'b0;
          end
        end
      end
    end
  end

endmodule

// [src/mbas_frame_tx.v]
// Frame transmitter: wraps bytes in colon, hex pairs, check byte, CR LF.
// Assumes the sink takes a character on each cycle with tx_ready high.
`timescale 1ns/1ps
`include "mbas_regs.vh"

module mbas_frame_tx (
  input wire clk,
  input wire rst,
  input wire [7:0] byte_in,
  input wire byte_valid,
  input wire byte_last,
  output wire byte_ready,
  output reg [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready
);

  localparam S_IDLE = 9'b000000001;
  localparam S_START = 9'b000000010;
  localparam S_HI = 9'b000000100;
  localparam S_LO = 9'b000001000;
  localparam S_NEXT = 9'b000010000;
  localparam S_LRC_HI = 9'b000100000;
  localparam S_LRC_LO = 9'b001000000;
  localparam S_CR = 9'b010000000;
  localparam S_LF = 9'b100000000;

  reg [8:0] state_reg;
  reg [7:0] cur_reg;
  reg last_reg;
  reg [7:0] sum_reg;
  wire [7:0] lrc = 8'h00 - sum_reg;

  function [7:0] to_hex;
    input [3:0] n;
    begin
      if (n <= 4'h9) begin
        to_hex = {4'h3, n};
      end else begin
        to_hex = {4'h4, n - 4'h9};
      end
    end
  endfunction

  assign byte_ready = (state_reg == S_IDLE) || (state_reg == S_NEXT);
  assign tx_valid = !byte_ready;

  always @* begin
    case (state_reg)
      S_START: tx_data = `MBAS_CH_COLON;
      S_HI: tx_data = to_hex(cur_reg[7:4]);
      S_LO: tx_data = to_hex(cur_reg[3:0]);
      S_LRC_HI: tx_data = to_hex(lrc[7:4]);
      S_LRC_LO: tx_data = to_hex(lrc[3:0]);
      S_CR: tx_data = `MBAS_CH_CR;
      S_LF: tx_data = `MBAS_CH_LF;
      default: tx_data = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cur_reg <= 8'h00;
      last_reg <= 1'b0;
      sum_reg <= 8'h00;
    end else begin
      case (state_reg)
        S_IDLE: if (byte_valid) begin
          cur_reg <= byte_in;
          last_reg <= byte_last;
          sum_reg <= 8'h00;
          state_reg <= S_START;
        end
        S_NEXT: if (byte_valid) begin
          cur_reg <= byte_in;
          last_reg <= byte_last;
          state_reg <= S_HI;
        end
        S_START: if (tx_ready) state_reg <= S_HI;
        S_HI: if (tx_ready) state_reg <= S_LO;
        S_LO: if (tx_ready) begin
          sum_reg <= sum_reg + cur_reg;
          state_reg <= last_reg ? S_LRC_HI : S_NEXT;
        end
        S_LRC_HI: if (tx_ready) state_reg <= S_LRC_LO;
        S_LRC_LO: if (tx_ready) state_reg <= S_CR;
        S_CR: if (tx_ready) state_reg <= S_LF;
        S_LF: if (tx_ready) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// [verif/mbas_slave_sva.sv]
// Checker for the serial register slave, watching top-level ports only.
// Assumes it is bound onto mbas_slave and shares its MAX_REGS.
`timescale 1ns/1ps

module mbas_slave_sva #(
  parameter MAX_REGS = 16
) (
  input wire CLOCK,
  input wire SYS_RST,
  input wire [7:0] RX_CHAR,
  input wire RX_VALID,
  input wire [7:0] TX_CHAR,
  input wire TX_VALID,
  input wire TX_READY,
  input wire [15:0] SETPOINT,
  input wire [15:0] RUN_STOP,
  input wire RUN_CMD,
  input wire BUSY
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  reg [7:0] since_lf_reg;
  reg in_reply_reg;
  // Set from the accepted colon until the accepted line feed
  always @(posedge CLOCK) begin
    if (SYS_RST)
      in_reply_reg <= 1'b0;
    else if (TX_VALID && TX_READY)
      in_reply_reg <= (TX_CHAR != 8'h0A);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last line feed came in
  always @(posedge CLOCK) begin
    if (SYS_RST || (RX_VALID && RX_CHAR == 8'h0A))
      since_lf_reg <= 8'h00;
    else if (since_lf_reg != 8'hFF)
      since_lf_reg <= since_lf_reg + 8'h01;
  end
  sequence s_cr_sent;
    TX_VALID && TX_READY && TX_CHAR == 8'h0D;
  endsequence
  sequence s_lf_offered;
    ##[1:2] (TX_VALID && TX_CHAR == 8'h0A);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property ($fell(SYS_RST) |->
    !TX_VALID && SETPOINT == 16'h0000 && RUN_STOP == 16'h0000 && !RUN_CMD)
    else $error("outputs not quiet after reset");
  a_idle_silent: assert property ($rose(BUSY) |-> since_lf_reg == 8'h01)
    else $error("busy without a received frame end");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_CHAR))
    else $error("offered char dropped before acceptance");
  a_reply_colon: assert property (TX_VALID && !in_reply_reg |-> TX_CHAR == 8'h3A)
    else $error("reply does not open with colon");
  a_cr_then_lf: assert property (s_cr_sent |-> s_lf_offered)
    else $error("carriage return not followed by line feed");
  a_reply_delay: assert property ($rose(TX_VALID) && !in_reply_reg |->
    since_lf_reg >= 2 && since_lf_reg <= MAX_REGS + 5)
    else $error("reply start not tied to a received frame end");
  a_char_set: assert property (TX_VALID |-> TX_CHAR inside
    {8'h3A, 8'h0D, 8'h0A, [8'h30:8'h39], [8'h41:8'h46]})
    else $error("reply char outside frame alphabet");
  a_run_follow: assert property (RUN_CMD == (RUN_STOP == 16'h0001))
    else $error("run command disagrees with run flag register");
  a_setpt_busy: assert property (!$stable(SETPOINT) |-> $past(BUSY))
    else $error("setpoint changed outside a request");
endmodule

bind mbas_slave mbas_slave_sva #(.MAX_REGS(MAX_REGS)) u_mbas_slave_sva (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .RX_CHAR(RX_CHAR), .RX_VALID(RX_VALID),
  .TX_CHAR(TX_CHAR), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .SETPOINT(SETPOINT),
  .RUN_STOP(RUN_STOP), .RUN_CMD(RUN_CMD), .BUSY(BUSY));

// [verif/mbas_host_model.sv]
// Host model: sends ASCII frames to the slave and collects its replies.
// Assumes one char per cycle on receive; stalls replies when slow is set.
`timescale 1ns/1ps

module mbas_host_model (
  input wire clk,
  input wire slow,
  output reg [7:0] rx_char,
  output reg rx_valid,
  input wire [7:0] tx_char,
  input wire tx_valid,
  output wire tx_ready
);
  logic [7:0] got[$];
  reg [15:0] sr_reg = 16'hACE1;
  initial rx_char = 8'h00;
  initial rx_valid = 1'b0;
  assign tx_ready = !slow || sr_reg[0];
  always @(posedge clk) begin
    sr_reg <= {sr_reg[14:0], sr_reg[15] ^ sr_reg[13] ^ sr_reg[12] ^ sr_reg[10]};
    if (tx_valid && tx_ready)
      got.push_back(tx_char);
  end
  function automatic [7:0] hx(input [3:0] n);
    hx = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // Colon, hex pairs, check byte, CR LF; flip spoils the check byte
  task automatic build(input logic [7:0] m[$], input logic [7:0] flip,
                       output logic [7:0] f[$]);
    logic [7:0] sum;
    sum = 8'h00;
    f = '{8'h3A};
    foreach (m[i]) begin
      sum += m[i];
      f.push_back(hx(m[i][7:4]));
      f.push_back(hx(m[i][3:0]));
    end
    sum = (8'h00 - sum) ^ flip;
    f.push_back(hx(sum[7:4]));
    f.push_back(hx(sum[3:0]));
    f.push_back(8'h0D);
    f.push_back(8'h0A);
  endtask
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge clk);
      #1;
      rx_char = f[i];
      rx_valid = 1'b1;
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_char = ~rx_char;
  endtask
endmodule

// [verif/mbas_slave_test.sv]
// Self-checking bench for the serial register slave.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module mbas_slave_test;
  typedef logic [7:0] mbas_bytes_t[$];
  reg CLOCK = 1'b0;
  reg SYS_RST = 1'b1;
  reg [7:0] SLAVE_ADDR = 8'h01;
  reg [15:0] live [0:5];
  reg slow = 1'b0;
  reg [31:0] lfsr_state = 32'hB305;
  reg [15:0] sp_exp = 16'h0000;
  reg [15:0] rs_exp = 16'h0000;
  reg [15:0] v;
  int n_mismatch = 0;
  int comparisons = 0;
  int h;
  wire [7:0] rx_char, tx_char;
  wire rx_valid, tx_valid, tx_ready, run_cmd, busy;
  wire [15:0] setpoint, run_stop;
  mbas_slave #(.MAX_REGS(16)) u_mbas_slave (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .RX_CHAR(rx_char), .RX_VALID(rx_valid), .TX_CHAR(tx_char), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .SLAVE_ADDR(SLAVE_ADDR), .OUTLET_TEMP(live[0]),
    .OUTLET_PRESS(live[1]), .RESISTIVITY(live[2]), .STATUS_FLAGS_1(live[3]),
    .ALARM_FLAGS_1(live[4]), .ALARM_FLAGS_2(live[5]), .SETPOINT(setpoint),
    .RUN_STOP(run_stop), .RUN_CMD(run_cmd), .BUSY(busy));
  mbas_host_model u_mbas_host_model (.clk(CLOCK), .slow(slow), .rx_char(rx_char),
    .rx_valid(rx_valid), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial begin
    forever #20 CLOCK = ~CLOCK;
  end
  ////////////////////////////////////////////////////////////////////////////
  function logic [15:0] rnd();
    lfsr_state = {lfsr_state[30:0],
                  lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    rnd = lfsr_state[15:0];
  endfunction
  function logic [15:0] word_at(input int a);
    word_at = (a == 1) ? 16'h0000 : (a < 7) ? live[(a == 0) ? 0 : a - 1] :
              (a == 11) ? sp_exp : (a == 12) ? rs_exp : 16'h0000;
  endfunction
  // Read reply: address, code, byte count, words ascending
  function mbas_bytes_t rd_reply(input logic [7:0] a, input int hd, input int n);
    rd_reply = '{a, 8'h03, 8'(2 * n)};
    for (int k = hd; k < hd + n; k++) begin
      rd_reply.push_back(word_at(k) >> 8);
      rd_reply.push_back(word_at(k) & 16'h00FF);
    end
  endfunction
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Fault 1 spoils the check byte, 2 drops the line feed, 3 sends lower case
  task run(input logic [7:0] m[$], input int fault, input logic [7:0] r[$]);
    logic [7:0] f[$];
    logic [7:0] e[$];
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 500) begin
      @(posedge CLOCK);
      #1;
      i++;
    end
    u_mbas_host_model.build(m, (fault == 1) ? 8'h01 : 8'h00, f);
    if (fault == 2)
      void'(f.pop_back());
    if (fault == 3)
      foreach (f[q])
        if (f[q] >= 8'h41 && f[q] <= 8'h46)
          f[q] = f[q] + 8'h20;
    u_mbas_host_model.got.delete();
    u_mbas_host_model.send(f);
    u_mbas_host_model.build(r, 8'h00, e);
    if (r.size() == 0)
      e.delete();
    i = 0;
    while (u_mbas_host_model.got.size() < e.size() && i < 3000) begin
      @(posedge CLOCK);
      #1;
      i++;
    end
    repeat (80) @(posedge CLOCK);
    chk("reply length", 16'(u_mbas_host_model.got.size()), 16'(e.size()));
    foreach (e[k])
      if (k < u_mbas_host_model.got.size())
        chk("reply char", u_mbas_host_model.got[k], e[k]);
  endtask
  task rd(input logic [7:0] a, input int hd, input int n, input int fault, input logic ok);
    mbas_bytes_t r;
    r = {};
    if (ok)
      r = rd_reply(a, hd, n);
    run('{a, 8'h03, 8'h00, 8'(hd), 8'h00, 8'(n)}, fault, r);
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge CLOCK);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    for (int k = 0; k < 6; k++)
      live[k] = rnd();
    repeat (2) @(posedge CLOCK);
    #1;
    SYS_RST = 1'b0;
    chk("setpoint", setpoint, 16'h0000);
    rd(8'h01, 0, 7, 0, 1'b1);
    v = 16'h0001;
    run('{8'h01, 8'h06, 8'h00, 8'h0C, 8'h00, 8'h01}, 0,
        '{8'h01, 8'h06, 8'h00, 8'h0C, 8'h00, 8'h01});
    rs_exp = 16'h0001;
    chk("run flag", run_stop, rs_exp);
    chk("run cmd", run_cmd, 16'h0001);
    v = rnd();
    run('{8'h01, 8'h10, 8'h00, 8'h0B, 8'h00, 8'h02, 8'h04, v[15:8], v[7:0], 8'h00, 8'h00},
        0, '{8'h01, 8'h10, 8'h00, 8'h0B, 8'h00, 8'h02});
    sp_exp = v;
    rs_exp = 16'h0000;
    chk("setpoint", setpoint, sp_exp);
    chk("run flag", run_stop, rs_exp);
    chk("run cmd", run_cmd, 16'h0000);
    run('{8'h01, 8'h06, 8'h00, 8'h0B, 8'h00, 8'hAF}, 3,
        '{8'h01, 8'h06, 8'h00, 8'h0B, 8'h00, 8'hAF});
    sp_exp = 16'h00AF;
    chk("setpoint", setpoint, sp_exp);
    for (int j = 0; j < 6; j++) begin
      slow <= rnd() & 16'h0001;
      for (int k = 0; k < 6; k++)
        live[k] <= rnd();
      h = rnd() % 13;
      @(posedge CLOCK);
      rd(8'h01, h, 1 + rnd() % (13 - h), 0, 1'b1);
    end
    SLAVE_ADDR <= 8'h2A;
    slow <= 1'b1;
    rd(8'h01, 0, 1, 0, 1'b0);
    rd(8'h2A, 0, 1, 0, 1'b1);
    SLAVE_ADDR <= 8'h01;
    rd(8'h01, 2, 3, 1, 1'b0);
    rd(8'h01, 2, 3, 2, 1'b0);
    rd(8'h01, 4, 3, 0, 1'b1);
    report_and_stop;
  end
endmodule
